// *** pkg/bsc_pkg.sv ***
// shared constants and types of the board system-control block
package bsc_pkg;

  localparam int unsigned    CLK_PERIOD_NS    = 50;
  localparam int unsigned    WD_TIMEOUT_US    = 1000000;
  localparam int unsigned    WD_TIMEOUT_CYC   = (WD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  localparam int unsigned    ADDR_W           = 8;
  localparam logic [7:0]     OFS_CMD          = 8'h00;
  localparam logic [7:0]     OFS_RUN          = 8'h04;
  localparam logic [7:0]     OFS_STATUS       = 8'h08;
  localparam logic [7:0]     OFS_DISPLAY      = 8'h0c;
  localparam logic [7:0]     OFS_SEGCODE      = 8'h10;
  localparam logic [7:0]     OFS_LED          = 8'h14;
  localparam logic [7:0]     OFS_ROTARY       = 8'h18;

  // command register bit positions (write one to act)
  localparam int unsigned    CMD_WD_START     = 0;
  localparam int unsigned    CMD_WD_KICK      = 1;
  localparam int unsigned    CMD_HALF_EN      = 2;
  localparam int unsigned    CMD_HALF_DIS     = 3;
  localparam int unsigned    CMD_HALF_CLR     = 4;
  localparam int unsigned    CMD_BTN_EN       = 5;
  localparam int unsigned    CMD_BTN_DIS      = 6;
  localparam int unsigned    CMD_BTN_CLR      = 7;
  localparam int unsigned    CMD_LED_ON       = 8;
  localparam int unsigned    CMD_LED_OFF      = 9;
  localparam int unsigned    CMD_LED_TOGGLE   = 10;
  localparam int unsigned    CMD_KICK_ALIAS   = 11;

  // status register bit positions
  localparam int unsigned    ST_RUNNING       = 0;
  localparam int unsigned    ST_HALF_PEND     = 1;
  localparam int unsigned    ST_HALF_EN       = 2;
  localparam int unsigned    ST_BTN_PEND      = 3;
  localparam int unsigned    ST_BTN_EN        = 4;
  localparam int unsigned    ST_LED_LIT       = 5;
  localparam int unsigned    ST_FLASH_RDY     = 6;
  localparam int unsigned    ST_EXPIRED       = 7;

  localparam logic [1:0]     RESP_OKAY        = 2'h0;
  localparam logic [1:0]     RESP_SLVERR      = 2'h2;
  localparam logic [7:0]     DISPLAY_RST      = 8'h00;

  typedef enum logic [1:0] {LED_BLACK, LED_GREEN, LED_RED, LED_YELLOW} bsc_colour_t;
  typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_EXPIRED} bsc_wd_t;

  typedef struct packed {
    logic        abort_n;
    logic [3:0]  rotary;
    logic        flash_ready;
  } bsc_panel_in_t;

  typedef struct packed {
    logic [7:0]  display;
    logic        led_red;
    logic        led_green;
  } bsc_panel_out_t;

  typedef struct packed {
    bsc_wd_t       wd;
    logic [31:0]   cnt;
    logic          half_en;
    logic          half_pend;
    logic          btn_en;
    logic          btn_pend;
    logic          nmi;
    logic          expired;
    logic          btn_irq;
    bsc_colour_t   colour;
    logic [7:0]    display;
    logic [3:0]    seg_val;
    logic          abort_s1;
    logic          abort_s2;
    logic          abort_s3;
    logic [3:0]    rot_s1;
    logic [3:0]    rot_s2;
    logic          rdy_s1;
    logic          rdy_s2;
    logic          aw_held;
    logic [7:0]    awaddr_h;
    logic          w_held;
    logic [31:0]   wdata_h;
    logic [3:0]    wstrb_h;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } bsc_state_t;

endpackage

// *** design/bsc_top.sv ***
// board system control: watchdog, abort button, display, led, rotary and flash status
// Functional notes
// [RL1] start command begins watchdog counting immediately
// [RL2] once running, stop requests are ignored
// [RL3] half interval raises interrupt when enabled
// [RL4] disabled half interrupt is never generated
// [RL5] half interval interrupt drives nmi line
// [RL6] half interval pending flag is readable
// [RL7] software clear removes half interval pending
// [RL8] kick restarts count; software kicks in time
// [RL9] enabled abort press raises an interrupt
// [RL10] disabled abort press raises no interrupt
// [RL11] abort pending flag is readable
// [RL12] software clear removes abort pending
// [RL13] display byte held, drives segments directly
// [RL14] segment conversion uses low four bits
// [RL15] led colours black green red yellow
// [RL16] led on lights yellow
// [RL17] led lit state is readable
// [RL18] toggle flips led on and off
// [RL19] rotary position reads as zero to 15
// [RL20] flash ready status bit is readable
// [RL21] pending flags hold until cleared or reset
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module bsc_top
  import bsc_pkg::*;
#(
  parameter int unsigned WD_CYCLES = bsc_pkg::WD_TIMEOUT_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire bsc_pkg::bsc_panel_in_t  panel_in,
  output bsc_pkg::bsc_panel_out_t   panel_out,
  output logic                      nmi,
  output logic                      abort_irq,
  output logic                      wd_expired
);
  import bsc_pkg::*;

  localparam logic [31:0] HALF_CNT = 32'(WD_CYCLES / 2);
  localparam logic [31:0] FULL_CNT = 32'(WD_CYCLES);

  bsc_state_t s_q;
  bsc_state_t s_d;

  logic        wr_do;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] cmd;
  logic        cmd_start;
  logic        cmd_kick;
  logic        half_hit;
  logic        btn_press;
  logic        led_lit;
  logic        rd_take;
  logic [2:0]  rd_idx;

  // register index, 7 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    unique case (a)
      OFS_CMD:     reg_index = 3'h0;
      OFS_RUN:     reg_index = 3'h1;
      OFS_STATUS:  reg_index = 3'h2;
      OFS_DISPLAY: reg_index = 3'h3;
      OFS_SEGCODE: reg_index = 3'h4;
      OFS_LED:     reg_index = 3'h5;
      OFS_ROTARY:  reg_index = 3'h6;
      default:     reg_index = 3'h7;
    endcase
  endfunction

  function automatic logic [6:0] seg_code(input logic [3:0] v);
    unique case (v)
      4'h0: seg_code = 7'h3f;
      4'h1: seg_code = 7'h06;
      4'h2: seg_code = 7'h5b;
      4'h3: seg_code = 7'h4f;
      4'h4: seg_code = 7'h66;
      4'h5: seg_code = 7'h6d;
      4'h6: seg_code = 7'h7d;
      4'h7: seg_code = 7'h07;
      4'h8: seg_code = 7'h7f;
      4'h9: seg_code = 7'h6f;
      4'ha: seg_code = 7'h77;
      4'hb: seg_code = 7'h7c;
      4'hc: seg_code = 7'h39;
      4'hd: seg_code = 7'h5e;
      4'he: seg_code = 7'h79;
      4'hf: seg_code = 7'h71;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    // two-stage synchronisers, third stage only for the press edge
    s_d.abort_s1 = panel_in.abort_n;
    s_d.abort_s2 = s_q.abort_s1;
    s_d.abort_s3 = s_q.abort_s2;
    s_d.rot_s1   = panel_in.rotary;
    s_d.rot_s2   = s_q.rot_s1;
    s_d.rdy_s1   = panel_in.flash_ready;
    s_d.rdy_s2   = s_q.rdy_s1;
    btn_press    = s_q.abort_s3 && !s_q.abort_s2;
    led_lit      = (s_q.colour != LED_BLACK);
    rd_take      = ce && s_axi_arvalid && s_q.arready;
    rd_idx       = reg_index(s_axi_araddr);

    // write channel capture, either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held  = 1'b1;
      s_d.awaddr_h = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held  = 1'b1;
      s_d.wdata_h = s_axi_wdata;
      s_d.wstrb_h = s_axi_wstrb;
    end
    wr_do = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_q.wstrb_h[i]}};
    end
    wval = s_q.wdata_h & wmask;
    cmd  = (wr_do && reg_index(s_q.awaddr_h) == 3'h0) ? wval : 32'h0;
    cmd_start = cmd[CMD_WD_START] ||
                (wr_do && reg_index(s_q.awaddr_h) == 3'h1 && wval[0]);
    cmd_kick  = cmd[CMD_WD_KICK] || cmd[CMD_KICK_ALIAS];

    if (wr_do) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (reg_index(s_q.awaddr_h) == 3'h7) ? RESP_SLVERR : RESP_OKAY;
      unique case (reg_index(s_q.awaddr_h))
        3'h3: s_d.display = (s_q.display & ~wmask[7:0]) | wval[7:0]; // [RL13]
        3'h4: if (s_q.wstrb_h[0]) s_d.seg_val = s_q.wdata_h[3:0]; // [RL14]
        3'h5: if (s_q.wstrb_h[0]) s_d.colour = bsc_colour_t'(s_q.wdata_h[1:0]); // [RL15]
        default: ;
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready  = !s_d.w_held && !s_d.bvalid;

    // led commands; off beats on, on beats toggle
    if (cmd[CMD_LED_TOGGLE]) begin
      s_d.colour = led_lit ? LED_BLACK : LED_YELLOW; // [RL18]
    end
    if (cmd[CMD_LED_ON]) begin
      s_d.colour = LED_YELLOW; // [RL16]
    end
    if (cmd[CMD_LED_OFF]) begin
      s_d.colour = LED_BLACK; // [RL15]
    end

    // watchdog; a zero run-control write is a stop that is never honoured
    half_hit = 1'b0;
    unique case (s_q.wd)
      WD_IDLE: begin
        if (cmd_start) begin
          s_d.wd  = WD_RUN; // [RL1]
          s_d.cnt = 32'h0;
        end
      end
      WD_RUN: begin
        if (cmd_kick) begin
          s_d.cnt = 32'h0; // [RL8]
        end else if (s_q.cnt == FULL_CNT - 32'h1) begin
          s_d.wd = WD_EXPIRED;
        end else begin
          s_d.cnt  = s_q.cnt + 32'h1; // [RL2]
          half_hit = (s_q.cnt == HALF_CNT - 32'h1);
        end
      end
      WD_EXPIRED: ;
    endcase
    s_d.expired = (s_d.wd == WD_EXPIRED);

    // half-interval flag: set wins over clear
    if (cmd[CMD_HALF_EN]) s_d.half_en = 1'b1;
    if (cmd[CMD_HALF_DIS]) s_d.half_en = 1'b0; // [RL4]
    if (cmd[CMD_HALF_CLR]) s_d.half_pend = 1'b0; // [RL7]
    if (half_hit && s_q.half_en) s_d.half_pend = 1'b1; // [RL3] [RL21]
    s_d.nmi = s_d.half_pend && s_d.half_en; // [RL5]

    // abort button flag: set wins over clear
    if (cmd[CMD_BTN_EN]) s_d.btn_en = 1'b1;
    if (cmd[CMD_BTN_DIS]) s_d.btn_en = 1'b0; // [RL10]
    if (cmd[CMD_BTN_CLR]) s_d.btn_pend = 1'b0; // [RL12]
    if (btn_press && s_q.btn_en) s_d.btn_pend = 1'b1; // [RL9] [RL21]
    s_d.btn_irq = s_d.btn_pend && s_d.btn_en;

    // read channel
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = RESP_OKAY;
      s_d.rdata   = 32'h0;
      unique case (reg_index(s_axi_araddr))
        3'h1: s_d.rdata[0] = (s_q.wd != WD_IDLE);
        3'h2: begin
          s_d.rdata[ST_RUNNING]   = (s_q.wd == WD_RUN);
          s_d.rdata[ST_HALF_PEND] = s_q.half_pend; // [RL6]
          s_d.rdata[ST_HALF_EN]   = s_q.half_en;
          s_d.rdata[ST_BTN_PEND]  = s_q.btn_pend; // [RL11]
          s_d.rdata[ST_BTN_EN]    = s_q.btn_en;
          s_d.rdata[ST_LED_LIT]   = led_lit; // [RL17]
          s_d.rdata[ST_FLASH_RDY] = s_q.rdy_s2; // [RL20]
          s_d.rdata[ST_EXPIRED]   = (s_q.wd == WD_EXPIRED);
        end
        3'h3: s_d.rdata[7:0] = s_q.display;
        3'h4: s_d.rdata[6:0] = seg_code(s_q.seg_val); // [RL14]
        3'h5: s_d.rdata[1:0] = s_q.colour;
        3'h6: s_d.rdata[3:0] = s_q.rot_s2; // [RL19]
        3'h7: s_d.rresp = RESP_SLVERR;
        default: ;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{wd: WD_IDLE, colour: LED_BLACK, display: DISPLAY_RST,
               abort_s1: 1'b1, abort_s2: 1'b1, abort_s3: 1'b1,
               awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign panel_out.display   = s_q.display; // [RL13]
  assign panel_out.led_red   = s_q.colour[1]; // [RL15]
  assign panel_out.led_green = s_q.colour[0];
  assign nmi           = s_q.nmi;
  assign abort_irq     = s_q.btn_irq;
  assign wd_expired    = s_q.expired;

  a_start_runs: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    ce && cmd_start && s_q.wd == WD_IDLE |=> s_q.wd == WD_RUN && s_q.cnt == 32'h0)
    else $error("start command did not start the watchdog");

  a_no_stop: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    s_q.wd != WD_IDLE |=> s_q.wd != WD_IDLE)
    else $error("running watchdog returned to idle");

  a_half_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    ce && s_q.wd == WD_RUN && !cmd_kick && s_q.cnt == HALF_CNT - 32'h1 && s_q.half_en
    |=> s_q.half_pend && (nmi || !s_q.half_en))
    else $error("half interval did not raise the interrupt");

  a_dis_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    !s_q.half_en && !s_q.half_pend |=> !s_q.half_pend)
    else $error("half interrupt set while disabled");

  a_nmi_line: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
    nmi == (s_q.half_pend && s_q.half_en))
    else $error("nmi line does not follow pending half interrupt");

  a_half_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    ce && cmd[CMD_HALF_CLR] && !half_hit |=> !s_q.half_pend)
    else $error("clear did not remove half interrupt");

  a_kick_restart: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    ce && cmd_kick && s_q.wd == WD_RUN |=> s_q.cnt == 32'h0 && s_q.wd == WD_RUN)
    else $error("kick did not restart the count");

  a_btn_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
    ce && btn_press && s_q.btn_en |=> s_q.btn_pend && (abort_irq || !s_q.btn_en))
    else $error("abort press lost");

  a_btn_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    s_q.btn_pend && !(ce && cmd[CMD_BTN_CLR]) |=> s_q.btn_pend)
    else $error("abort pending dropped without clear");

  a_led_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
    ce && cmd[CMD_LED_TOGGLE] && !cmd[CMD_LED_ON] && !cmd[CMD_LED_OFF]
    |=> (s_q.colour == LED_BLACK) == $past(led_lit))
    else $error("toggle did not flip the led");

  a_half_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    s_q.half_pend && !(ce && cmd[CMD_HALF_CLR]) |=> s_q.half_pend)
    else $error("half pending dropped without clear");

  a_btn_dis_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
    !s_q.btn_en && !s_q.btn_pend |=> !s_q.btn_pend && !abort_irq)
    else $error("abort interrupt raised while disabled");

  a_btn_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
    ce && cmd[CMD_BTN_CLR] && !(btn_press && s_q.btn_en) |=> !s_q.btn_pend && !abort_irq)
    else $error("clear did not remove abort interrupt");

  a_disp_write: assert property (@(posedge aclk) disable iff (!aresetn) // [RL13]
    ce && wr_do && reg_index(s_q.awaddr_h) == 3'h3 && s_q.wstrb_h[0]
    |=> panel_out.display == $past(s_q.wdata_h[7:0]))
    else $error("display byte not driven to the segments");

  a_seg_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    ce && wr_do && reg_index(s_q.awaddr_h) == 3'h4 && s_q.wstrb_h[0]
    |=> s_q.seg_val == $past(s_q.wdata_h[3:0]))
    else $error("segment value not the low four bits");

  a_led_on_yel: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    ce && cmd[CMD_LED_ON] && !cmd[CMD_LED_OFF] |=> panel_out.led_red && panel_out.led_green)
    else $error("led on did not light yellow");

  a_led_black: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
    ce && cmd[CMD_LED_OFF] |=> !panel_out.led_red && !panel_out.led_green)
    else $error("led off left the led lit");

  a_half_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
    rd_take && rd_idx == 3'h2 |=> s_axi_rdata[ST_HALF_PEND] == $past(s_q.half_pend))
    else $error("half pending flag misread");

  a_btn_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    rd_take && rd_idx == 3'h2 |=> s_axi_rdata[ST_BTN_PEND] == $past(s_q.btn_pend))
    else $error("abort pending flag misread");

  a_led_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL17]
    rd_take && rd_idx == 3'h2 |=> s_axi_rdata[ST_LED_LIT] == ($past(s_q.colour) != LED_BLACK))
    else $error("led lit flag misread");

  a_rot_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
    rd_take && rd_idx == 3'h6 |=> s_axi_rdata == {28'h0, $past(s_q.rot_s2)})
    else $error("rotary position misread");

  a_flash_read: assert property (@(posedge aclk) disable iff (!aresetn) // [RL20]
    rd_take && rd_idx == 3'h2 |=> s_axi_rdata[ST_FLASH_RDY] == $past(s_q.rdy_s2))
    else $error("flash ready flag misread");

endmodule
`default_nettype wire

// *** verification/bsc_panel_model.sv ***
// front panel stand-in: abort button, rotary switch, flash status, led watch
`timescale 1ns/1ns
`default_nettype none
module bsc_panel_model
  import bsc_pkg::*;
#(
  parameter int unsigned PRESS_CYC = 6
) (
  input  wire logic                    aclk,
  input  wire logic                    press_req,
  input  wire logic [3:0]              pos,
  input  wire logic                    rdy,
  input  wire bsc_pkg::bsc_panel_out_t panel_out,
  output bsc_pkg::bsc_panel_in_t       panel_in,
  output logic [1:0]                   colour_seen
);
  int unsigned hold = 0;

  // a request becomes a press held for several cycles, like a real finger
  always @(posedge aclk) begin
    if (press_req)
      hold <= PRESS_CYC;
    else if (hold != 0)
      hold <= hold - 1;
  end

  always_comb begin
    panel_in.abort_n     = (hold == 0);
    panel_in.rotary      = pos;
    panel_in.flash_ready = rdy;
  end

  assign colour_seen = {panel_out.led_red, panel_out.led_green};
endmodule
`default_nettype wire

// *** verification/bsc_top_tb.sv ***
// self-checking bench of the board system-control block
`timescale 1ns/1ns
`default_nettype none
module bsc_top_tb;
  import bsc_pkg::*;
  localparam int unsigned WDC = 16;
  logic           aclk, aresetn, ce, press_req, rdy, nmi, abort_irq, wd_expired;
  logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic           s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]    s_axi_wdata, s_axi_rdata, d;
  logic [3:0]     s_axi_wstrb, pos;
  logic [1:0]     s_axi_bresp, s_axi_rresp, colour_seen;
  bsc_panel_in_t  panel_in;
  bsc_panel_out_t panel_out;
  int             n_errors = 0;
  int             num_checks = 0;
  int             k;

  bsc_top #(.WD_CYCLES(WDC)) dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .panel_in, .panel_out, .nmi, .abort_irq, .wd_expired
  );
  bsc_panel_model #(.PRESS_CYC(6)) panel (
    .aclk, .press_req, .pos, .rdy, .panel_out, .panel_in, .colour_seen
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic give_up();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    int i;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 40) give_up();
    chk(s_axi_bresp, er, "bresp");
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    int i;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 40) give_up();
    v = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    tick(8);
    aresetn <= 1'b1;
  endtask

  task automatic t_regs();
    // let the pin synchronisers fill before status is read
    tick(2);
    rd(OFS_STATUS, d);
    chk(d, 32'h40, "status after reset");
    rd(OFS_LED, d);
    chk(d, 32'h0, "led after reset");
    rd(8'h1c, d, RESP_SLVERR);
    chk(d, 32'h0, "unmapped read");
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(OFS_ROTARY, 32'h5);
  endtask

  task automatic t_disp();
    wr(OFS_DISPLAY, 32'h1234_56a5);
    chk(panel_out.display, 8'ha5, "display pins");
    s_axi_wstrb <= 4'he;
    wr(OFS_DISPLAY, 32'h0000_005a);
    s_axi_wstrb <= 4'hf;
    chk(panel_out.display, 8'ha5, "masked lane kept");
    rd(OFS_DISPLAY, d);
    chk(d, 32'ha5, "display read");
    wr(OFS_SEGCODE, 32'hf3);
    rd(OFS_SEGCODE, d);
    chk(d, 32'h4f, "segment of 3");
    wr(OFS_SEGCODE, 32'h18);
    rd(OFS_SEGCODE, d);
    chk(d, 32'h7f, "segment of 8");
  endtask

  task automatic t_led();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_LED, 32'(c));
      chk(colour_seen, c[1:0], "colour");
      rd(OFS_STATUS, d);
      chk(d[ST_LED_LIT], c != 0, "lit flag");
    end
    wr(OFS_CMD, 32'h200);
    chk(colour_seen, 2'b00, "led off");
    wr(OFS_CMD, 32'h400);
    chk(colour_seen, 2'b11, "toggle on");
    wr(OFS_CMD, 32'h400);
    chk(colour_seen, 2'b00, "toggle off");
    wr(OFS_CMD, 32'h100);
    chk(colour_seen, 2'b11, "led on yellow");
  endtask

  task automatic press();
    press_req <= 1'b1;
    @(posedge aclk);
    press_req <= 1'b0;
  endtask

  task automatic t_btn();
    wr(OFS_CMD, 32'h20);
    press();
    for (k = 0; k < 12 && abort_irq !== 1'b1; k++) @(posedge aclk);
    chk(k < 12, 1'b1, "abort irq");
    if (k == 12) give_up();
    tick(10);
    chk(abort_irq, 1'b1, "abort held");
    rd(OFS_STATUS, d);
    chk(d[ST_BTN_PEND], 1'b1, "abort pending");
    wr(OFS_CMD, 32'h80);
    chk(abort_irq, 1'b0, "abort cleared");
    rd(OFS_STATUS, d);
    chk(d[ST_BTN_PEND], 1'b0, "abort pending cleared");
    wr(OFS_CMD, 32'h40);
    press();
    tick(12);
    chk(abort_irq, 1'b0, "abort disabled");
    rd(OFS_STATUS, d);
    chk(d[ST_BTN_PEND], 1'b0, "no pending while disabled");
  endtask

  task automatic t_rot();
    for (int p = 0; p < 16; p++) begin
      pos <= 4'(p);
      rdy <= p[0];
      tick(3);
      rd(OFS_ROTARY, d);
      chk(d, 32'(p), "rotary");
      rd(OFS_STATUS, d);
      chk(d[ST_FLASH_RDY], p[0], "flash ready");
    end
  endtask

  task automatic t_wd_half();
    rst();
    wr(OFS_CMD, 32'h4);
    wr(OFS_CMD, 32'h1);
    for (k = 0; k < 12 && nmi !== 1'b1; k++) @(posedge aclk);
    chk(k >= 6 && k <= 10, 1'b1, "half interval nmi");
    if (k == 12) give_up();
    for (k = 0; k < 20 && wd_expired !== 1'b1; k++) @(posedge aclk);
    chk(k >= 6 && k <= 10, 1'b1, "expiry time");
    if (k == 20) give_up();
    tick(5);
    chk(nmi, 1'b1, "nmi held");
    rd(OFS_STATUS, d);
    chk(d[ST_HALF_PEND], 1'b1, "half pending");
    wr(OFS_CMD, 32'h8);
    chk(nmi, 1'b0, "nmi off when disabled");
    wr(OFS_CMD, 32'h10);
    rd(OFS_STATUS, d);
    chk(d[ST_HALF_PEND], 1'b0, "half cleared");
  endtask

  task automatic t_wd_dis();
    rst();
    wr(OFS_CMD, 32'h4);
    wr(OFS_CMD, 32'h8);
    wr(OFS_RUN, 32'h1);
    tick(12);
    chk(nmi, 1'b0, "no nmi when disabled");
    rd(OFS_STATUS, d);
    chk(d[ST_HALF_PEND], 1'b0, "no pending when disabled");
  endtask

  task automatic t_wd_kick();
    rst();
    wr(OFS_RUN, 32'h0);
    rd(OFS_RUN, d);
    chk(d[0], 1'b0, "stop before start");
    wr(OFS_CMD, 32'h4);
    wr(OFS_RUN, 32'h1);
    // alternate the two kick bits, one write every four cycles
    for (int n = 0; n < 6; n++) wr(OFS_CMD, n[0] ? 32'h800 : 32'h2);
    wr(OFS_RUN, 32'h0);
    chk(nmi, 1'b0, "kicked, no nmi");
    chk(wd_expired, 1'b0, "kicked, no expiry");
    for (k = 0; k < 12 && nmi !== 1'b1; k++) @(posedge aclk);
    chk(k < 12, 1'b1, "nmi after kicks stop");
    if (k == 12) give_up();
    for (k = 0; k < 20 && wd_expired !== 1'b1; k++) @(posedge aclk);
    chk(k < 20, 1'b1, "stop ignored");
    if (k == 20) give_up();
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    press_req = 1'b0;
    pos = 4'h0;
    rdy = 1'b1;
    rst();
    t_regs();
    t_disp();
    t_led();
    t_btn();
    t_rot();
    t_wd_half();
    t_wd_dis();
    t_wd_kick();
    test_done();
  end
endmodule
`default_nettype wire
